// File: rtl/cpsc_pkg.sv
/*
 package for the chip power-state controller: register map, field layouts,
 reset values, state list and timing counts.
 assumes a 125 MHz system clock and 32-bit word-aligned register access.
*/
package cpsc_pkg;
   localparam int CLK_KHZ = 125000;
   localparam int CM_WAIT_US = 35000;
   localparam int CM_WAIT_CYC = (CM_WAIT_US * (CLK_KHZ / 1000));
   localparam int DOM_UP_CYC = 16;
   localparam int CNT_W = 23;

   localparam logic [7:0] OFS_PWR_CTRL = 8'h00;
   localparam logic [7:0] OFS_CORE_EN = 8'h04;
   localparam logic [7:0] OFS_BLOCK_EN = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_IRQ_FLAG = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

   typedef struct packed {
      logic master_block_en;
      logic main_core_fast_mode;
      logic core_mem_retain;
      logic clock_tree_ungate;
      logic common_mode_hold_on;
      logic power_en;
   } cpsc_ctrl_s;

   typedef struct packed {
      logic fast_core_enable;
      logic main_core_enable;
      logic pll_enable;
   } cpsc_core_s;

   localparam logic [5:0] CTRL_RST = 6'h06;
   localparam logic [2:0] CORE_RST = 3'h0;
   localparam logic [1:0] MASK_RST = 2'h3;
   localparam logic [1:0] FLAG_RST = 2'h0;

   typedef enum logic [2:0] {
      ST_HW_SHUT,
      ST_SW_PD,
      ST_CM_WAIT,
      ST_DOM_UP,
      ST_PLL_WAIT,
      ST_ACTIVE
   } cpsc_state_e;
endpackage : cpsc_pkg

// File: rtl/cpsc_top.sv
/*
 chip power-state controller: hardware shutdown, software power-down,
 power-up sequencing, power-up-done flags and block enable gating.
 assumes a host on the plain register port and asynchronous shutdown,
 pll lock and regulator-select pins.
*/
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module cpsc_top #(
   parameter int N_CH = 8,
   parameter int CM_WAIT_CYC = cpsc_pkg::CM_WAIT_CYC,
   parameter int DOM_UP_CYC = cpsc_pkg::DOM_UP_CYC
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic shutdown_n_pin,
   input wire logic reg_select_pin,
   input wire logic pll_lock_pin,
   input wire logic [7:0] addr,
   input wire logic [31:0] wr_data,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [31:0] rd_data,
   output logic regulator_on,
   output logic common_mode_on,
   output logic osc_on,
   output logic clk_ungate,
   output logic dig_domain_pwr,
   output logic core_mem_pwr,
   output logic pll_enable_o,
   output logic main_core_en_o,
   output logic fast_core_en_o,
   output logic main_core_fast_o,
   output logic [N_CH-1:0] block_en_o,
   output logic powerup_complete,
   output logic irq_line1,
   output logic irq_line2
);
   logic sd_s1_r, sd_s2_r, rs_s1_r, rs_s2_r, pl_s1_r, pl_s2_r;
   logic rst_int;
   cpsc_pkg::cpsc_state_e state_r, state_nxt;
   cpsc_pkg::cpsc_ctrl_s ctrl_r;
   cpsc_pkg::cpsc_core_s core_r;
   logic [N_CH-1:0] chan_r;
   logic [1:0] flag_r, mask_r;
   logic [cpsc_pkg::CNT_W-1:0] cnt_r;
   logic cm_ready_r, done_r;
   logic wr_pwr, wr_core, wr_chan, wr_flag, wr_mask, enter_active;

   // pins cross into clk_sys through two flops each
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         sd_s1_r <= 1'b0;
         sd_s2_r <= 1'b0;
         rs_s1_r <= 1'b0;
         rs_s2_r <= 1'b0;
         pl_s1_r <= 1'b0;
         pl_s2_r <= 1'b0;
      end
      else
      begin
         sd_s1_r <= shutdown_n_pin;
         sd_s2_r <= sd_s1_r;
         rs_s1_r <= reg_select_pin;
         rs_s2_r <= rs_s1_r;
         pl_s1_r <= pll_lock_pin;
         pl_s2_r <= pl_s1_r;
      end
   end

   // synchronised pin low is a full internal reset
   assign rst_int = rst | ~sd_s2_r;

   // writes only land outside shutdown; reset dominates anyway
   always_comb
   begin
      wr_pwr = 1'b0;
      wr_core = 1'b0;
      wr_chan = 1'b0;
      wr_flag = 1'b0;
      wr_mask = 1'b0;
      if (wr_stb && addr == cpsc_pkg::OFS_PWR_CTRL)
         wr_pwr = 1'b1;
      else if (wr_stb && addr == cpsc_pkg::OFS_CORE_EN)
         wr_core = 1'b1;
      else if (wr_stb && addr == cpsc_pkg::OFS_BLOCK_EN)
         wr_chan = 1'b1;
      else if (wr_stb && addr == cpsc_pkg::OFS_IRQ_FLAG)
         wr_flag = 1'b1;
      else if (wr_stb && addr == cpsc_pkg::OFS_IRQ_MASK)
         wr_mask = 1'b1;
   end

   // control registers live in the always-on domain
   always_ff @(posedge clk_sys)
   begin
      if (rst_int)
      begin
         ctrl_r <= cpsc_pkg::CTRL_RST;
         core_r <= cpsc_pkg::CORE_RST;
         chan_r <= '0;
         mask_r <= cpsc_pkg::MASK_RST;
      end
      else
      begin
         if (wr_pwr)
            ctrl_r <= wr_data[5:0];
         if (wr_core)
            core_r <= wr_data[2:0];
         if (wr_chan)
            chan_r <= wr_data[N_CH-1:0];
         if (wr_mask)
            mask_r <= wr_data[1:0];
      end
   end

   // state sequencer
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         cpsc_pkg::ST_HW_SHUT: state_nxt = cpsc_pkg::ST_SW_PD;
         cpsc_pkg::ST_SW_PD:
            if (ctrl_r.power_en)
               state_nxt = cm_ready_r ? cpsc_pkg::ST_DOM_UP : cpsc_pkg::ST_CM_WAIT;
         cpsc_pkg::ST_CM_WAIT:
            if (cnt_r == '0)
               state_nxt = cpsc_pkg::ST_DOM_UP;
         cpsc_pkg::ST_DOM_UP:
            if (cnt_r == '0)
               state_nxt = cpsc_pkg::ST_PLL_WAIT;
         cpsc_pkg::ST_PLL_WAIT:
            if (pl_s2_r || !core_r.pll_enable)
               state_nxt = cpsc_pkg::ST_ACTIVE;
         default: state_nxt = state_r;
      endcase
      if (state_r != cpsc_pkg::ST_HW_SHUT && !ctrl_r.power_en)
         state_nxt = cpsc_pkg::ST_SW_PD;
   end

   assign enter_active = state_r == cpsc_pkg::ST_PLL_WAIT && state_nxt == cpsc_pkg::ST_ACTIVE;

   always_ff @(posedge clk_sys)
   begin
      if (rst_int)
         state_r <= cpsc_pkg::ST_HW_SHUT;
      else
         state_r <= state_nxt;
   end

   // one counter serves both the common-mode and domain waits
   always_ff @(posedge clk_sys)
   begin
      if (rst_int)
         cnt_r <= '0;
      else if (state_r == cpsc_pkg::ST_SW_PD)
         cnt_r <= cm_ready_r ? cpsc_pkg::CNT_W'(DOM_UP_CYC - 1) : cpsc_pkg::CNT_W'(CM_WAIT_CYC - 1);
      else if (state_r == cpsc_pkg::ST_CM_WAIT && cnt_r == '0)
         cnt_r <= cpsc_pkg::CNT_W'(DOM_UP_CYC - 1);
      else if (cnt_r != '0)
         cnt_r <= cnt_r - 1'b1;
   end

   // common mode counts as charged after the wait or on shutdown exit with hold set; power-down keeps it only if hold stays on
   always_ff @(posedge clk_sys)
   begin
      if (rst_int)
         cm_ready_r <= 1'b0;
      else if (state_r == cpsc_pkg::ST_CM_WAIT && cnt_r == '0)
         cm_ready_r <= 1'b1;
      else if (state_r == cpsc_pkg::ST_SW_PD)
         cm_ready_r <= ctrl_r.common_mode_hold_on && cm_ready_r;
      else if (state_r == cpsc_pkg::ST_HW_SHUT)
         cm_ready_r <= ctrl_r.common_mode_hold_on;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst_int)
         done_r <= 1'b0;
      else
         done_r <= state_nxt == cpsc_pkg::ST_ACTIVE;
   end

   // set beats a same-cycle write-one-to-clear
   always_ff @(posedge clk_sys)
   begin
      if (rst_int)
         flag_r <= cpsc_pkg::FLAG_RST;
      else
         flag_r <= (flag_r & ~(wr_flag ? wr_data[1:0] : 2'h0)) | {2{enter_active}};
   end

   // power controls; the domain power and the pll enable wait on common mode
   always_ff @(posedge clk_sys)
   begin
      if (rst_int)
      begin
         regulator_on <= 1'b0;
         common_mode_on <= 1'b0;
         osc_on <= 1'b0;
         clk_ungate <= 1'b0;
         dig_domain_pwr <= 1'b0;
         core_mem_pwr <= 1'b0;
         pll_enable_o <= 1'b0;
         main_core_en_o <= 1'b0;
         fast_core_en_o <= 1'b0;
         main_core_fast_o <= 1'b0;
         block_en_o <= '0;
         irq_line1 <= 1'b0;
         irq_line2 <= 1'b0;
      end
      else
      begin
         regulator_on <= rs_s2_r;
         common_mode_on <= ctrl_r.common_mode_hold_on || state_r != cpsc_pkg::ST_SW_PD;
         osc_on <= 1'b1;
         clk_ungate <= ctrl_r.clock_tree_ungate;
         dig_domain_pwr <= state_nxt != cpsc_pkg::ST_SW_PD && state_nxt != cpsc_pkg::ST_CM_WAIT;
         core_mem_pwr <= ctrl_r.core_mem_retain || dig_domain_pwr;
         pll_enable_o <= core_r.pll_enable && cm_ready_r && dig_domain_pwr;
         main_core_en_o <= core_r.main_core_enable && done_r;
         fast_core_en_o <= core_r.fast_core_enable && done_r;
         main_core_fast_o <= ctrl_r.main_core_fast_mode;
         block_en_o <= (ctrl_r.master_block_en && done_r) ? chan_r : '0;
         irq_line1 <= flag_r[0] && !mask_r[0];
         irq_line2 <= flag_r[1] && !mask_r[1];
      end
   end

   assign powerup_complete = done_r;

   // read data valid one cycle after the strobe, zero otherwise
   always_ff @(posedge clk_sys)
   begin
      if (rst_int)
         rd_data <= 32'h00000000;
      else if (!rd_stb)
         rd_data <= 32'h00000000;
      else if (addr == cpsc_pkg::OFS_PWR_CTRL)
         rd_data <= {26'h0000000, ctrl_r};
      else if (addr == cpsc_pkg::OFS_CORE_EN)
         rd_data <= {29'h00000000, core_r};
      else if (addr == cpsc_pkg::OFS_BLOCK_EN)
         rd_data <= 32'(chan_r);
      else if (addr == cpsc_pkg::OFS_STATUS)
         rd_data <= {25'h0000000, cm_ready_r, rs_s2_r, pl_s2_r, done_r, 3'h0} | {29'h0, state_r};
      else if (addr == cpsc_pkg::OFS_IRQ_FLAG)
         rd_data <= {30'h00000000, flag_r};
      else if (addr == cpsc_pkg::OFS_IRQ_MASK)
         rd_data <= {30'h00000000, mask_r};
      else
         rd_data <= 32'h00000000;
   end

   sequence active_entry_s;
      state_r == cpsc_pkg::ST_PLL_WAIT ##1 state_r == cpsc_pkg::ST_ACTIVE;
   endsequence

   shut_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
      !sd_s2_r |=> state_r == cpsc_pkg::ST_HW_SHUT && ctrl_r == cpsc_pkg::CTRL_RST)
      else $error("registers not held in shutdown");
   shut_ignore_a: assert property (@(posedge clk_sys) disable iff (rst)
      !sd_s2_r && rd_stb |=> rd_data == 32'h00000000)
      else $error("read answered in shutdown");
   exit_swpd_a: assert property (@(posedge clk_sys) disable iff (rst_int)
      state_r == cpsc_pkg::ST_HW_SHUT && !rst_int |=> state_r == cpsc_pkg::ST_SW_PD)
      else $error("shutdown exit not to power-down");
   pd_keep_a: assert property (@(posedge clk_sys) disable iff (rst_int)
      state_r == cpsc_pkg::ST_SW_PD && !wr_stb |=> $stable(ctrl_r) && $stable(chan_r))
      else $error("register lost in power-down");
   reg_keep_a: assert property (@(posedge clk_sys) disable iff (rst_int)
      state_r == cpsc_pkg::ST_SW_PD ##1 state_r == cpsc_pkg::ST_SW_PD |-> regulator_on == $past(rs_s2_r))
      else $error("regulator select ignored");
   pwr_leave_a: assert property (@(posedge clk_sys) disable iff (rst_int)
      state_r == cpsc_pkg::ST_SW_PD && ctrl_r.power_en |=> state_r != cpsc_pkg::ST_SW_PD)
      else $error("power enable did not leave power-down");
   pwr_return_a: assert property (@(posedge clk_sys) disable iff (rst_int)
      state_r == cpsc_pkg::ST_ACTIVE && !ctrl_r.power_en |=> state_r == cpsc_pkg::ST_SW_PD ##2 !powerup_complete)
      else $error("clearing power enable did not return");
   cm_gate_a: assert property (@(posedge clk_sys) disable iff (rst_int)
      pll_enable_o |-> $past(cm_ready_r))
      else $error("pll enabled before common mode charged");
   clk_gate_a: assert property (@(posedge clk_sys) disable iff (rst_int)
      !ctrl_r.clock_tree_ungate ##1 state_r == cpsc_pkg::ST_SW_PD |-> !clk_ungate)
      else $error("clocks not gated");
   dom_off_a: assert property (@(posedge clk_sys) disable iff (rst_int)
      state_r == cpsc_pkg::ST_SW_PD [*2] |-> !dig_domain_pwr)
      else $error("digital domain powered in power-down");
   done_flag_a: assert property (@(posedge clk_sys) disable iff (rst_int)
      active_entry_s |-> flag_r == 2'h3 && powerup_complete)
      else $error("done flags not raised on completion");
   mask_a: assert property (@(posedge clk_sys) disable iff (rst_int)
      irq_line1 || irq_line2 |-> !(irq_line1 && $past(mask_r[0])) && !(irq_line2 && $past(mask_r[1])))
      else $error("interrupt through set mask");
   master_a: assert property (@(posedge clk_sys) disable iff (rst_int)
      !ctrl_r.master_block_en |=> block_en_o == '0)
      else $error("block enabled with master off");
endmodule : cpsc_top

// File: test/cpsc_host_model.sv
/*
 host model: plain register port master for the power-state controller.
 assumes strobes sampled on rising clk_sys and read data one cycle later.
*/
`timescale 1ns/1ps
module cpsc_host_model #(
   parameter int SETTLE_CYC = 8
) (
   input wire logic clk_sys,
   input wire logic [31:0] rd_data,
   output logic [7:0] addr,
   output logic [31:0] wr_data,
   output logic wr_stb,
   output logic rd_stb
);
   // left clear: model assumes the low core supply
   localparam logic [31:0] FAST_BIT = 32'h00000010;
   initial
   begin
      addr = 8'h00;
      wr_data = 32'h00000000;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
   end
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      addr <= a;
      wr_data <= d & ~FAST_BIT;
      wr_stb <= 1'b1;
      @(posedge clk_sys);
      wr_stb <= 1'b0;
      wr_data <= ~d; // released bus must not keep last value
   endtask : reg_write
   task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk_sys);
      rd_stb <= 1'b0;
      #1;
      d = rd_data;
   endtask : reg_read
   // shortened regulator settle time after pin release
   task automatic settle();
      repeat (SETTLE_CYC) @(posedge clk_sys);
   endtask : settle
   task automatic power_down(input logic [31:0] ctrl);
      reg_write(cpsc_pkg::OFS_BLOCK_EN, 32'h00000000); // mute first
      reg_write(cpsc_pkg::OFS_PWR_CTRL, ctrl & ~32'h00000020); // master off
      reg_write(cpsc_pkg::OFS_PWR_CTRL, ctrl & ~32'h00000021); // then power
   endtask : power_down
endmodule : cpsc_host_model

// File: test/cpsc_top_tb.sv
/*
 testbench for the chip power-state controller.
 assumes the host model for register traffic; pins driven here.
*/
`timescale 1ns/1ps
module cpsc_top_tb;
   localparam int CMW = 20;
   logic clk_sys, rst, shutdown_n_pin, reg_select_pin, pll_lock_pin;
   logic [7:0] addr;
   logic [31:0] wr_data, rd_data;
   logic wr_stb, rd_stb, regulator_on, common_mode_on, osc_on, clk_ungate;
   logic dig_domain_pwr, core_mem_pwr, pll_enable_o, main_core_en_o, fast_core_en_o;
   logic main_core_fast_o, powerup_complete, irq_line1, irq_line2;
   logic [7:0] block_en_o;
   int fails, cmp_count, n;
   cpsc_host_model i_cpsc_host_model (.clk_sys(clk_sys), .rd_data(rd_data), .addr(addr),
      .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb));
   cpsc_top #(.N_CH(8), .CM_WAIT_CYC(CMW), .DOM_UP_CYC(4)) i_cpsc_top (.clk_sys(clk_sys), .rst(rst),
      .shutdown_n_pin(shutdown_n_pin), .reg_select_pin(reg_select_pin), .pll_lock_pin(pll_lock_pin),
      .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
      .regulator_on(regulator_on), .common_mode_on(common_mode_on), .osc_on(osc_on),
      .clk_ungate(clk_ungate), .dig_domain_pwr(dig_domain_pwr), .core_mem_pwr(core_mem_pwr),
      .pll_enable_o(pll_enable_o), .main_core_en_o(main_core_en_o), .fast_core_en_o(fast_core_en_o),
      .main_core_fast_o(main_core_fast_o), .block_en_o(block_en_o),
      .powerup_complete(powerup_complete), .irq_line1(irq_line1), .irq_line2(irq_line2));
   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      cmp_count++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string msg);
      logic [31:0] d;
      i_cpsc_host_model.reg_read(a, d);
      chk(d & m, e, msg);
   endtask : rd_chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_cpsc_host_model.reg_write(a, d);
   endtask : wr
   // bounded wait: sel 0 domain power, 1 power-up complete
   task automatic wait_hi(input int sel, input int lim, output int cnt);
      cnt = 0;
      while ((sel == 0 ? dig_domain_pwr : powerup_complete) !== 1'b1)
      begin
         @(posedge clk_sys);
         #1;
         cnt++;
         if (cnt > lim)
         begin
            fails++;
            $display("wrong value at %0t: wait ran out", $time);
            report_and_stop();
         end
      end
   endtask : wait_hi
   initial
   begin
      fails = 0;
      cmp_count = 0;
      rst = 1'b1;
      shutdown_n_pin = 1'b1;
      reg_select_pin = 1'b1;
      pll_lock_pin = 1'b0;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (4) @(posedge clk_sys);
      i_cpsc_host_model.settle();
      #1;
      chk(32'({osc_on, common_mode_on, regulator_on, clk_ungate, dig_domain_pwr}), 32'h1E, "pd outs");
      rd_chk(cpsc_pkg::OFS_PWR_CTRL, 32'hFFFFFFFF, 32'h06, "ctrl reset");
      rd_chk(cpsc_pkg::OFS_IRQ_MASK, 32'hFFFFFFFF, 32'h3, "mask reset");
      rd_chk(cpsc_pkg::OFS_STATUS, 32'h7, 32'h1, "state after reset");
      rd_chk(8'h20, 32'hFFFFFFFF, 32'h0, "unmapped read");
      wr(cpsc_pkg::OFS_CORE_EN, 32'h7);
      wr(cpsc_pkg::OFS_BLOCK_EN, 32'hA5);
      wr(cpsc_pkg::OFS_IRQ_MASK, 32'h2); // unmask line 1 only
      wr(cpsc_pkg::OFS_PWR_CTRL, 32'h2E);
      repeat (4) @(posedge clk_sys);
      #1;
      chk(32'({dig_domain_pwr, block_en_o, pll_enable_o}), 32'h0, "off before enable");
      wr(cpsc_pkg::OFS_PWR_CTRL, 32'h2F);
      wait_hi(0, 50, n);
      repeat (20) @(posedge clk_sys);
      #1;
      chk(32'(powerup_complete), 32'h0, "complete before lock");
      @(posedge clk_sys);
      pll_lock_pin <= 1'b1;
      wait_hi(1, 20, n);
      repeat (2) @(posedge clk_sys);
      #1;
      chk(32'({irq_line1, irq_line2, main_core_en_o, fast_core_en_o, pll_enable_o}), 32'h17, "active");
      chk(32'(block_en_o), 32'hA5, "channel enables");
      chk(32'(main_core_fast_o), 32'h0, "fast mode off");
      rd_chk(cpsc_pkg::OFS_STATUS, 32'hF, 32'hD, "status active");
      wr(cpsc_pkg::OFS_PWR_CTRL, 32'h0F);
      repeat (2) @(posedge clk_sys);
      #1;
      chk(32'({block_en_o, main_core_en_o, pll_enable_o}), 32'h3, "master off");
      wr(cpsc_pkg::OFS_IRQ_FLAG, 32'h1);
      repeat (2) @(posedge clk_sys);
      #1;
      chk(32'(irq_line1), 32'h0, "flag cleared");
      i_cpsc_host_model.power_down(32'h0F);
      repeat (3) @(posedge clk_sys);
      #1;
      chk(32'({powerup_complete, dig_domain_pwr, core_mem_pwr}), 32'h1, "retained pd");
      rd_chk(cpsc_pkg::OFS_PWR_CTRL, 32'hFFFFFFFF, 32'h0E, "ctrl kept");
      rd_chk(cpsc_pkg::OFS_CORE_EN, 32'hFFFFFFFF, 32'h7, "cores kept");
      wr(cpsc_pkg::OFS_PWR_CTRL, 32'h00);
      @(posedge clk_sys);
      reg_select_pin <= 1'b0;
      repeat (5) @(posedge clk_sys);
      #1;
      chk(32'({core_mem_pwr, clk_ungate, common_mode_on, regulator_on, osc_on}), 32'h1, "lowest");
      @(posedge clk_sys);
      reg_select_pin <= 1'b1;
      wr(cpsc_pkg::OFS_PWR_CTRL, 32'h05);
      wait_hi(0, 100, n);
      chk(32'(n >= CMW - 1), 32'h1, "charge wait");
      wait_hi(1, 50, n);
      @(posedge clk_sys);
      shutdown_n_pin <= 1'b0;
      repeat (4) @(posedge clk_sys);
      #1;
      chk(32'({powerup_complete, osc_on, dig_domain_pwr, regulator_on}), 32'h0, "shutdown");
      wr(cpsc_pkg::OFS_IRQ_MASK, 32'h0);
      rd_chk(cpsc_pkg::OFS_IRQ_MASK, 32'hFFFFFFFF, 32'h0, "read in shutdown");
      @(posedge clk_sys);
      shutdown_n_pin <= 1'b1;
      repeat (6) @(posedge clk_sys);
      rd_chk(cpsc_pkg::OFS_IRQ_MASK, 32'hFFFFFFFF, 32'h3, "write lost");
      rd_chk(cpsc_pkg::OFS_PWR_CTRL, 32'hFFFFFFFF, 32'h06, "ctrl back");
      rd_chk(cpsc_pkg::OFS_CORE_EN, 32'hFFFFFFFF, 32'h0, "cores back");
      rd_chk(cpsc_pkg::OFS_STATUS, 32'h7, 32'h1, "state sw pd");
      report_and_stop();
   end
endmodule : cpsc_top_tb
